// file: flash_map_info_overlay.sv
// address decode for program flash with read-only information overlay
// assumes the flash array answers reads in the same cycle as rd, that page-select
// and protect writes are decoded elsewhere and arrive as strobes, and unlock as a level
//
// How it works
// - up to 64 KB flash, contiguous from address zero, readable and writable
// - program/erase accepted from cpu software or the debug interface
// - flash divided in 512-byte pages; erase clears one whole page
// - eight sectors (six in the 24K and 48K variants), each individually protectable against program and erase
// - sector size 2K, 4K or 8K by variant; sector n at n times size
// - page-select bit 7 written as one enables the information area
// - enabled overlay maps info area over FE00 to FFFF
// - table reads in overlaid range return information-area data
// - instruction fetches always return normal flash contents
// - information area is read-only; writes there change nothing
// - part id string of 20 bytes at FE40 to FE53, zero padded
`timescale 1ns/100ps
module flash_map_info_overlay
#(
    parameter logic [159:0] PART_ID = 160'h0  // arbitrary neutral id
)
(
    input  wire logic                      mclk_i,
    input  wire logic                      rstn_i,
    input  wire flash_map_pkg::size_e      size_i,
    input  wire flash_map_pkg::cpu_req_s   req_i,
    input  wire logic                      page_sel_wr_i,
    input  wire logic [7:0]                page_sel_data_i,
    input  wire logic                      prot_wr_i,
    input  wire logic [7:0]                prot_data_i,
    input  wire logic                      unlocked_i,
    input  wire logic [7:0]                arr_rdata_i,
    output flash_map_pkg::arr_cmd_s        arr_cmd_o,
    output logic [7:0]                     rdata_o,
    output logic                           rvalid_o,
    output logic                           info_ena_o,
    output logic [7:0]                     prot_o,
    output logic                           refused_o
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]  page_sel;
    logic [7:0]  next_page_sel;
    logic [7:0]  prot;
    logic [7:0]  next_prot;
    logic        info_rd;
    logic        next_info_rd;
    logic        arr_rd;
    logic        next_arr_rd;
    logic [7:0]  info_data;
    logic [7:0]  next_info_data;
    logic        refused;
    logic        next_refused;
    flash_map_pkg::arr_cmd_s arr_cmd;
    flash_map_pkg::arr_cmd_s next_arr_cmd;

    logic [2:0]  sector;
    logic [7:0]  exists;
    logic        in_range;
    logic        in_overlay;
    logic        sect_prot;
    logic        same_page;
    logic [7:0]  id_byte [flash_map_pkg::IDSTR_LEN];
    logic [15:0] id_off;

    flash_sector_decode u_sector
    (
        .size_i     (size_i),
        .addr_i     (req_i.addr),
        .sector_o   (sector),
        .exists_o   (exists),
        .in_range_o (in_range)
    );

    // ------------------------------------------------------------
    // information area contents
    // ------------------------------------------------------------
    generate
        for (genvar g = 0; g < flash_map_pkg::IDSTR_LEN; g++)
        begin : g_id
            // first character stands at the lowest address
            assign id_byte[g] = PART_ID[159-8*g -: 8];
        end
    endgenerate

    assign id_off = req_i.addr - flash_map_pkg::IDSTR_BASE;
    assign in_overlay = page_sel[flash_map_pkg::INFO_ENA_BIT]
                      && (req_i.addr >= flash_map_pkg::INFO_BASE);
    assign sect_prot = prot[sector] && exists[sector];
    assign same_page = (req_i.addr[15:flash_map_pkg::PAGE_SHIFT] == page_sel[6:0]);

    // ------------------------------------------------------------
    // next-state decode
    // ------------------------------------------------------------
    always_comb
    begin
        next_page_sel  = page_sel;
        next_prot      = prot;
        next_info_rd   = 1'b0;
        next_arr_rd    = 1'b0;
        next_info_data = info_data;
        next_refused   = 1'b0;
        next_arr_cmd   = '0;
        if (page_sel_wr_i)
        begin
            next_page_sel = page_sel_data_i;
        end
        if (prot_wr_i)
        begin
            next_prot = prot | (prot_data_i & exists);
        end
        if (req_i.valid)
        begin
            next_arr_cmd.addr  = req_i.addr;
            next_arr_cmd.wdata = req_i.wdata;
            if (req_i.write || req_i.erase)
            begin
                // cpu or debug may program; overlay, protected or foreign pages refused
                if (in_overlay || !in_range || sect_prot || !unlocked_i || !same_page)
                begin
                    next_refused = 1'b1;
                end
                else
                begin
                    next_arr_cmd.prog       = req_i.write;
                    next_arr_cmd.page_erase = req_i.erase && !req_i.write;
                end
            end
            else if (in_overlay && !req_i.fetch)
            begin
                next_info_rd = 1'b1;
                if (id_off < 16'(flash_map_pkg::IDSTR_LEN))
                begin
                    next_info_data = id_byte[id_off[4:0]];
                end
                else
                begin
                    next_info_data = flash_map_pkg::RSVD_BYTE;
                end
            end
            else if (in_range)
            begin
                next_arr_cmd.rd = 1'b1;
                next_arr_rd     = 1'b1;
            end
            else
            begin
                next_info_rd   = 1'b1;
                next_info_data = flash_map_pkg::ERASED_BYTE;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            page_sel  <= flash_map_pkg::PAGE_RST;
            prot      <= flash_map_pkg::PROT_RST;
            info_rd   <= 1'b0;
            arr_rd    <= 1'b0;
            info_data <= flash_map_pkg::RSVD_BYTE;
            refused   <= 1'b0;
            arr_cmd   <= '0;
        end
        else
        begin
            page_sel  <= next_page_sel;
            prot      <= next_prot;
            info_rd   <= next_info_rd;
            arr_rd    <= next_arr_rd;
            info_data <= next_info_data;
            refused   <= next_refused;
            arr_cmd   <= next_arr_cmd;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign arr_cmd_o  = arr_cmd;
    assign info_ena_o = page_sel[flash_map_pkg::INFO_ENA_BIT];
    assign prot_o     = prot;
    assign refused_o  = refused;
    assign rvalid_o   = info_rd || arr_rd;
    assign rdata_o    = info_rd ? info_data : arr_rdata_i;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_table_rd_overlay;
        req_i.valid && !req_i.fetch && !req_i.write && !req_i.erase && in_overlay;
    endsequence

    chk_overlay_table_read: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        s_table_rd_overlay |=> info_rd && !arr_cmd.rd)
        else $error("table read in overlay did not return info data");

    chk_fetch_from_array: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.fetch && !req_i.write && !req_i.erase && in_range
        |=> arr_cmd.rd && !info_rd)
        else $error("fetch not served by flash array");

    chk_info_readonly: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && (req_i.write || req_i.erase) && in_overlay
        |=> refused && !arr_cmd.prog && !arr_cmd.page_erase)
        else $error("write reached info area");

    chk_protect_sticky: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        ($past(prot) & ~prot) == 8'h00)
        else $error("protection bit cleared");

    chk_protected_refused: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        req_i.valid && req_i.write && sect_prot |=> refused && !arr_cmd.prog)
        else $error("program reached protected sector");

    chk_phantom_sectors: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        (size_i == flash_map_pkg::SIZE_24K || size_i == flash_map_pkg::SIZE_48K)
        && $stable(size_i) |-> prot[7:6] == $past(prot[7:6]))
        else $error("protection taken for missing sector");

    chk_info_enable: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        page_sel_wr_i |=> info_ena_o == $past(page_sel_data_i[7]))
        else $error("info enable not following bit 7");

    chk_id_range: assert property (@(posedge mclk_i) disable iff (!rstn_i)
        s_table_rd_overlay and (req_i.addr > flash_map_pkg::IDSTR_LAST)
        |=> info_data == flash_map_pkg::RSVD_BYTE)
        else $error("reserved info byte not blank");
endmodule

// file: flash_map_pkg.sv
// flash map constants, variant table and request/answer carriers
// assumes a 16-bit program-memory address space and byte-wide flash data
package flash_map_pkg;

    localparam int unsigned ADDR_W        = 16;
    localparam int unsigned PAGE_BYTES    = 512;
    localparam int unsigned PAGE_SHIFT    = 9;
    localparam int unsigned NUM_SECTORS   = 8;
    localparam int unsigned SEC_SHIFT_2K  = 11;
    localparam int unsigned SEC_SHIFT_4K  = 12;
    localparam int unsigned SEC_SHIFT_8K  = 13;
    localparam int unsigned IDSTR_LEN     = 20;
    localparam int unsigned INFO_ENA_BIT  = 7;

    localparam logic [15:0] INFO_BASE     = 16'hFE00;
    localparam logic [15:0] IDSTR_BASE    = 16'hFE40;
    localparam logic [15:0] IDSTR_LAST    = 16'hFE53;
    localparam logic [7:0]  ERASED_BYTE   = 8'hFF;
    localparam logic [7:0]  RSVD_BYTE     = 8'hFF;
    localparam logic [7:0]  PAGE_RST      = 8'h00;
    localparam logic [7:0]  PROT_RST      = 8'h00;
    localparam logic [7:0]  ALL_SECT      = 8'hFF;
    localparam logic [7:0]  SIX_SECT      = 8'h3F;

    // size variant, encoded by flash size
    typedef enum logic [2:0] {
        SIZE_16K = 3'h0,
        SIZE_24K = 3'h1,
        SIZE_32K = 3'h2,
        SIZE_48K = 3'h3,
        SIZE_64K = 3'h4
    } size_e;

    // one cpu access: fetch, table read, or program/erase request
    typedef struct packed {
        logic               valid;
        logic               fetch;
        logic               write;
        logic               erase;
        logic               from_debug;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         wdata;
    } cpu_req_s;

    // array-side command after decode and protection
    typedef struct packed {
        logic               rd;
        logic               prog;
        logic               page_erase;
        logic [ADDR_W-1:0]  addr;
        logic [7:0]         wdata;
    } arr_cmd_s;

endpackage

// file: flash_sector_decode.sv
// sector number, existence and in-range check for one flash address
// assumes the size variant is static while the device runs
`timescale 1ns/100ps
module flash_sector_decode
(
    input  wire flash_map_pkg::size_e    size_i,
    input  wire logic [15:0]             addr_i,
    output logic [2:0]                   sector_o,
    output logic [7:0]                   exists_o,
    output logic                         in_range_o
);
    logic [15:0] top_addr;

    always_comb
    begin
        sector_o = 3'h0;
        exists_o = flash_map_pkg::ALL_SECT;
        top_addr = 16'hFFFF;
        unique case (size_i)
            flash_map_pkg::SIZE_16K:
            begin
                sector_o = 3'(addr_i >> flash_map_pkg::SEC_SHIFT_2K);
                top_addr = 16'h3FFF;
            end
            flash_map_pkg::SIZE_24K:
            begin
                sector_o = 3'(addr_i >> flash_map_pkg::SEC_SHIFT_4K);
                exists_o = flash_map_pkg::SIX_SECT;
                top_addr = 16'h5FFF;
            end
            flash_map_pkg::SIZE_32K:
            begin
                sector_o = 3'(addr_i >> flash_map_pkg::SEC_SHIFT_4K);
                top_addr = 16'h7FFF;
            end
            flash_map_pkg::SIZE_48K:
            begin
                sector_o = 3'(addr_i >> flash_map_pkg::SEC_SHIFT_8K);
                exists_o = flash_map_pkg::SIX_SECT;
                top_addr = 16'hBFFF;
            end
            default:
            begin
                sector_o = 3'(addr_i >> flash_map_pkg::SEC_SHIFT_8K);
            end
        endcase
        in_range_o = (addr_i <= top_addr);
    end
endmodule

// file: flash_array_model.sv
// flash array model standing behind the map block
// assumes read data is taken during rd or in the cycle after it
`timescale 1ns/100ps
module flash_array_model
(
    input  wire flash_map_pkg::arr_cmd_s  cmd_i,
    input  wire logic                     mclk_i,
    output logic [7:0]                    rdata_o
);
    logic [15:0] last = 16'h0000;
    logic        hold = 1'b0;
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction
    always @(posedge mclk_i)
    begin
        hold <= cmd_i.rd;
        if (cmd_i.rd)
            last <= cmd_i.addr;
    end
    // data stands through rd and one cycle more, then turns over
    assign rdata_o = cmd_i.rd ? pat(cmd_i.addr) : (hold ? pat(last) : ~pat(last));
endmodule

// file: testbench.sv
// self-checking bench for the flash map and information overlay
// assumes the array model answers reads; results are queued and matched
`timescale 1ns/100ps
module testbench;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    localparam logic [159:0] PID = {"NEUTRALPARTID", 56'h0}; // arbitrary id
    logic                     mclk_i = 1'b0;
    logic                     rstn_i = 1'b0;
    flash_map_pkg::size_e     size_i = flash_map_pkg::SIZE_64K;
    flash_map_pkg::cpu_req_s  req_i = '0;
    logic                     page_sel_wr_i = 1'b0;
    logic [7:0]               page_sel_data_i = 8'h00;
    logic                     prot_wr_i = 1'b0;
    logic [7:0]               prot_data_i = 8'h00;
    logic                     unlocked_i = 1'b1;
    logic [7:0]               arr_rdata_i;
    flash_map_pkg::arr_cmd_s  arr_cmd_o;
    logic [7:0]               rdata_o;
    logic                     rvalid_o;
    logic                     info_ena_o;
    logic [7:0]               prot_o;
    logic                     refused_o;
    logic [11:0]              notes[$];
    int                       miscompares = 0;
    int                       cmp_count = 0;
    int                       seed = 32'hcf9a_f813;
    always #12.5 mclk_i = ~mclk_i;
    flash_map_info_overlay #(.PART_ID(PID)) u_dut (.mclk_i(mclk_i), .rstn_i(rstn_i), .size_i(size_i),
        .req_i(req_i), .page_sel_wr_i(page_sel_wr_i), .page_sel_data_i(page_sel_data_i), .prot_wr_i(prot_wr_i),
        .prot_data_i(prot_data_i), .unlocked_i(unlocked_i), .arr_rdata_i(arr_rdata_i), .arr_cmd_o(arr_cmd_o),
        .rdata_o(rdata_o), .rvalid_o(rvalid_o), .info_ena_o(info_ena_o), .prot_o(prot_o), .refused_o(refused_o));
    flash_array_model u_arr (.cmd_i(arr_cmd_o), .mclk_i(mclk_i), .rdata_o(arr_rdata_i));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'ha5;
    endfunction
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic judge(input string nm, input logic [11:0] exp, input logic [11:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic cmp_read(input logic [11:0] n);
        judge("rdata_o", n, {rvalid_o, 3'b000, rdata_o});
    endtask
    task automatic cmp_cmd(input logic [11:0] n);
        judge("arr_cmd_o", n, {1'b0, arr_cmd_o.prog, arr_cmd_o.page_erase, refused_o,
            arr_cmd_o.prog ? (arr_cmd_o.wdata ^ arr_cmd_o.addr[7:0]) :
            arr_cmd_o.page_erase ? {1'b0, arr_cmd_o.addr[15:9]} : 8'h00});
    endtask
    task automatic cmp_level(input string nm, input logic [7:0] exp, input logic [7:0] got);
        judge(nm, {4'h0, exp}, {4'h0, got});
    endtask
    task automatic do_reset(input flash_map_pkg::size_e s);
        if (rstn_i)
            repeat (2) @(posedge mclk_i);
        rstn_i <= 1'b0;
        size_i <= s;
        repeat (6) @(posedge mclk_i);
        rstn_i <= 1'b1;
    endtask
    task automatic access(input logic f, input logic w, input logic e, input logic [15:0] a,
                          input logic [7:0] wd, input logic [11:0] note);
        @(posedge mclk_i);
        req_i <= '{valid: 1'b1, fetch: f, write: w, erase: e, from_debug: seed[0], addr: a, wdata: wd};
        notes.push_back(note);
        @(posedge mclk_i);
        req_i.valid <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        access(1'b0, 1'b0, 1'b0, a, 8'h00, {4'b1000, exp});
    endtask
    task automatic fe(input logic [15:0] a, input logic [7:0] exp);
        access(1'b1, 1'b0, 1'b0, a, 8'h00, {4'b1000, exp});
    endtask
    task automatic pg(input logic [15:0] a, input logic [7:0] d, input logic ok);
        access(1'b0, 1'b1, 1'b0, a, d, ok ? {4'b0100, d ^ a[7:0]} : 12'h100);
    endtask
    task automatic er(input logic [15:0] a, input logic ok);
        access(1'b0, 1'b0, 1'b1, a, 8'h00, ok ? {4'b0010, 1'b0, a[15:9]} : 12'h100);
    endtask
    task automatic pulse_cfg(input logic prot, input logic [7:0] d);
        @(posedge mclk_i);
        page_sel_wr_i <= !prot;
        prot_wr_i <= prot;
        page_sel_data_i <= d;
        prot_data_i <= d;
        @(posedge mclk_i);
        page_sel_wr_i <= 1'b0;
        prot_wr_i <= 1'b0;
        @(posedge mclk_i);
        #1;
    endtask
    always @(negedge mclk_i)
        if (rstn_i && (rvalid_o | arr_cmd_o.prog | arr_cmd_o.page_erase | refused_o) !== 1'b0)
        begin
            if (notes.size() == 0)
                judge("unexpected result", 12'h000, 12'hfff);
            else if (notes[0][11])
                cmp_read(notes.pop_front());
            else
                cmp_cmd(notes.pop_front());
        end
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial
    begin : watchdog
        #500000;
        miscompares++;
        $display("watchdog expired");
        tally_and_finish();
    end
    initial
    begin : main
        logic [15:0] a;
        int          sh;
        for (int s = 0; s < 5; s++)
        begin
            do_reset(flash_map_pkg::size_e'(s));
            sh = (s == 0) ? 11 : (s < 3) ? 12 : 13;
            a = 16'(1 << sh) | 16'($random(seed) & 32'h0000_01ff);
            pulse_cfg(1'b0, 8'(a >> 9));
            pg(a, 8'($random(seed)), 1'b1);
            er(a, 1'b1);
            pulse_cfg(1'b1, 8'hc2);
            cmp_level("prot_o", (s == 1 || s == 3) ? 8'h02 : 8'hc2, prot_o);
            pg(a, 8'($random(seed)), 1'b0);
            er(a, 1'b0);
            a = 16'((1 << sh) - 1);
            pulse_cfg(1'b0, 8'(a >> 9));
            pg(a, 8'($random(seed)), 1'b1);
            if (s < 4)
            begin
                a = (s == 0) ? 16'h4000 : (s == 1) ? 16'h6000 : (s == 2) ? 16'h8000 : 16'hc000;
                pulse_cfg(1'b0, 8'(a >> 9));
                rd(a, 8'hff);
                pg(a, 8'h00, 1'b0);
            end
            $display("test variant %0d done", s);
        end
        do_reset(flash_map_pkg::SIZE_64K);
        pulse_cfg(1'b0, 8'hff);
        cmp_level("info_ena_o", 8'h01, {7'h00, info_ena_o});
        for (int i = 0; i < 20; i++)
            rd(16'hfe40 + 16'(i), PID[159 - 8 * i -: 8]);
        rd(16'hfe3f, 8'hff);
        rd(16'hfe54, 8'hff);
        rd(16'hfe00, 8'hff);
        rd(16'hfdff, pat(16'hfdff));
        fe(16'hfe40, pat(16'hfe40));
        fe(16'hffff, pat(16'hffff));
        pg(16'hfe40, 8'($random(seed)), 1'b0);
        er(16'hfe00, 1'b0);
        pulse_cfg(1'b0, 8'h7f);
        cmp_level("info_ena_o", 8'h00, {7'h00, info_ena_o});
        rd(16'hfe40, pat(16'hfe40));
        pg(16'hfe40, 8'($random(seed)), 1'b1);
        @(posedge mclk_i);
        unlocked_i <= 1'b0;
        pg(16'hfe41, 8'($random(seed)), 1'b0);
        $display("test overlay done");
        repeat (4) @(posedge mclk_i);
        cmp_level("pending notes", 8'h00, 8'(notes.size()));
        tally_and_finish();
    end
endmodule
